// ==== sim/nesu_flash_model.sv ====
/*
  ready/busy of two flash dies for the status unit bench.
  assumes a start_in pulse puts a die into busy.
*/
`timescale 1ns/1ps
module nesu_flash_model #(
  parameter int BUSY_CYC = 6
) (
  // clock
  input  wire logic       clk_in,
  // busy request, one bit a die
  input  wire logic [1:0] start_in,
  // ready/busy levels
  output logic      [1:0] ready_out
);
  int cnt [2];
  // busy for a fixed time after each request
  always_ff @(posedge clk_in) begin
    for (int i = 0; i < 2; i++) begin
      if (start_in[i]) cnt[i] <= BUSY_CYC;
      else if (cnt[i] > 0) cnt[i] <= cnt[i] - 1;
    end
  end
  // zero means busy, one means ready
  assign ready_out = {cnt[1] == 0, cnt[0] == 0};
endmodule

// ==== sim/nesu_status_unit_assertions.sv ====
/*
  concurrent checks on the status unit ports.
  assumes a bind to the unit and the header on the path.
*/
`timescale 1ns/1ps
`include "nesu_defs.svh"
module nesu_status_unit_assertions (
  // clock and reset
  input wire logic               clk_in,
  input wire logic               reset_in,
  // register port
  input nesu_pkg::nesu_bus_req_s bus_in,
  input wire logic [31:0]        rd_data_out,
  // pins and events
  input wire logic               ready_line_0_in,
  input wire logic               ready_line_1_in,
  input wire logic               chip_select_level_in,
  input wire logic [9:0]         boot_buffer_pointer_in,
  input wire logic               load_done_in,
  input wire logic               store_done_in,
  // controls
  input nesu_pkg::nesu_mode_e    mode_out,
  input wire logic               lock_tight_out,
  input wire logic               irq_out
);
  import nesu_pkg::*;
  // enable shadow; zero at reset only narrows the checks
  logic [2:0] ie;
  always_ff @(posedge clk_in) begin
    if (reset_in) ie <= 3'b000;
    else if (bus_in.wr && bus_in.addr == `NESU_OFS_CONTROL)
      ie <= bus_in.wdata[10:8];
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  sequence s_ctl_wr;
    bus_in.wr && bus_in.addr == `NESU_OFS_CONTROL;
  endsequence
  sequence s_flags_rd;
    bus_in.rd && bus_in.addr == `NESU_OFS_OP_FLAGS;
  endsequence
  chk_read_stands:
  assert property (rd_data_out != 32'h0000_0000 |-> $past(bus_in.rd))
    else $error("read data outside its cycle");
  chk_mode_write:
  assert property (s_ctl_wr |=> mode_out == $past(bus_in.wdata[1:0]))
    else $error("mode not taken from control write");
  chk_tight_set:
  assert property (s_ctl_wr ##0 bus_in.wdata[3] |=> lock_tight_out)
    else $error("lock tight not set");
  chk_tight_sticky:
  assert property (lock_tight_out |=> lock_tight_out)
    else $error("lock tight cleared");
  chk_load_irq:
  assert property (load_done_in && ie[0] |=> irq_out)
    else $error("no interrupt on load done");
  chk_store_irq:
  assert property (store_done_in && ie[1] |=> irq_out)
    else $error("no interrupt on store done");
  chk_edge_irq:
  assert property ($changed(ready_line_0_in) && ie[2] |-> ##[1:2] irq_out)
    else $error("no interrupt on ready edge");
  chk_irq_quiet:
  assert property (ie == 3'b000 ##1 ie == 3'b000 |-> !irq_out)
    else $error("interrupt while all disabled");
  chk_pin_mirror:
  assert property (s_flags_rd |=> rd_data_out[12:0] ==
    {$past(chip_select_level_in, 2), $past(ready_line_1_in, 2),
     $past(ready_line_0_in, 2), $past(boot_buffer_pointer_in, 2)})
    else $error("pin mirror wrong");
endmodule

// ==== sim/nesu_status_unit_test.sv ====
/*
  self-checking bench of the status unit.
  assumes design, model and checker compiled first.
*/
`timescale 1ns/1ps
`include "nesu_defs.svh"
module nesu_status_unit_test;
  import nesu_pkg::*;
  logic          clk_in = 0;
  logic          reset_in = 1;
  nesu_bus_req_s bus = '0;
  nesu_stored_s  stored = '0;
  logic [31:0]   rd_data;
  logic [1:0]    rdy;
  logic [1:0]    start = '0, cap_sel = '0;
  logic [2:0]    evt = '0;
  logic [9:0]    ptr = '0;
  logic [15:0]   data = '0, cap_d = '0;
  logic          cs = 1, rd_q = 0, clr = 0, vld = 0;
  logic          cap_v = 0, mchk = 0, schk = 0, spr = 0;
  nesu_mode_e    mode;
  logic          lock, tight, irq;
  int            errors = 0, checks_done = 0;
  logic [31:0]   exp_q [$];
  string         nm_q [$];
  logic [31:0]   ha [3] = '{`NESU_OFS_MAIN_HOLD3, `NESU_OFS_SPARE_HOLD0,
                            `NESU_OFS_SPARE_HOLD1};
  logic [23:0]   st [4] = '{24'h00_0000, 24'h00_0002, 24'h00_0003,
                            24'h00_300b};
  logic [7:0]    h3 [4] = '{8'h00, 8'h00, 8'h00, 8'h08};
  logic [31:0]   ex [4] = '{32'h0000_0000, 32'h0000_0003, 32'h0000_0002,
                            32'h0000_02b1};
  always #5 clk_in = ~clk_in;
  nesu_flash_model nesu_flash_model_i (.clk_in(clk_in), .start_in(start),
    .ready_out(rdy));
  nesu_status_unit nesu_status_unit_i (.clk_in(clk_in), .reset_in(reset_in),
    .bus_in(bus), .rd_data_out(rd_data), .ready_line_0_in(rdy[0]),
    .ready_line_1_in(rdy[1]), .chip_select_level_in(cs),
    .boot_buffer_pointer_in(ptr), .load_done_in(evt[0]),
    .store_done_in(evt[1]), .protected_attempt_in(evt[2]),
    .ecc_clear_in(clr), .ecc_valid_in(vld), .ecc_spare_in(spr),
    .ecc_data_in(data), .stored_main_in(stored), .cap_valid_in(cap_v),
    .cap_sel_in(cap_sel), .cap_data_in(cap_d), .main_check_in(mchk),
    .spare_check_in(schk), .mode_out(mode), .lock_out(lock),
    .lock_tight_out(tight), .irq_out(irq));
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(logic [31:0] a, logic [31:0] d);
    @(posedge clk_in);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    bus <= '0;
  endtask
  task automatic rd(logic [31:0] a, logic [31:0] e, string nm);
    @(posedge clk_in);
    bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    exp_q.push_back(e);
    nm_q.push_back(nm);
    @(posedge clk_in);
    bus <= '0;
  endtask
  task automatic ev(int k);
    @(posedge clk_in);
    evt <= 3'(1 << k);
    @(posedge clk_in);
    evt <= '0;
  endtask
  task automatic strobe(bit sp);
    @(posedge clk_in);
    if (sp) schk <= 1'b1;
    else mchk <= 1'b1;
    @(posedge clk_in);
    {schk, mchk} <= 2'b00;
  endtask
  // pins as driven now; callers let changes settle first
  function automatic logic [31:0] fl(logic [3:0] f);
    return {15'h0000, f, cs, rdy[1], rdy[0], ptr};
  endfunction
  // read data stand only in the cycle after rd
  always @(posedge clk_in) rd_q <= bus.rd;
  always @(negedge clk_in) begin
    if (rd_q === 1'b1) begin
      if (exp_q.size() == 0) check("queue", 32'h0000_0001, 32'h0000_0000);
      else check(nm_q.pop_front(), rd_data, exp_q.pop_front());
    end
  end
  initial begin
    #(100_000);
    errors++;
    stop_test();
  end
  initial begin
    logic [15:0] r;
    int          bp, n;
    void'($urandom(25));
    ptr <= 10'($urandom);
    repeat (3) @(posedge clk_in);
    reset_in <= 1'b0;
    check("locks", 32'({tight, lock}), 32'h0000_0001);
    rd(`NESU_OFS_OP_FLAGS, fl(4'h0), "flags reset");
    rd(`NESU_OFS_LANE_LOW, 32'h0000_0000, "low reset");
    rd(`NESU_OFS_LANE_HIGH, 32'h0000_0000, "high reset");
    foreach (ha[i]) begin
      r = 16'($urandom);
      rd(ha[i], 32'h0000_0000, "hold reset");
      wr(ha[i], {16'hffff, r});
      rd(ha[i], {16'h0000, r}, "hold rw");
    end
    wr(32'h40c0_0050, 32'hffff_ffff);
    rd(32'h40c0_0050, 32'h0000_0000, "unmapped");
    @(posedge clk_in);
    {cap_v, cap_sel, cap_d} <= {1'b1, 2'b00, r};
    @(posedge clk_in);
    cap_v <= 1'b0;
    rd(`NESU_OFS_MAIN_HOLD3, {16'h0000, r}, "capture");
    for (int m = 0; m < 4; m++) wr(`NESU_OFS_CONTROL, 32'h0000_0704 | m);
    cs <= 1'b0;
    ptr <= 10'($urandom);
    @(posedge clk_in);
    rd(`NESU_OFS_OP_FLAGS, fl(4'h0), "pin mirror");
    for (int k = 0; k < 3; k++) begin
      bp = (k == 2) ? 16 : 15 - k;
      ev(k);
      rd(`NESU_OFS_OP_FLAGS, fl(4'(1 << (bp - 13))), "set");
      wr(`NESU_OFS_OP_FLAGS, 32'h0000_0000);
      rd(`NESU_OFS_OP_FLAGS, fl(4'(1 << (bp - 13))), "zero wr");
      wr(`NESU_OFS_OP_FLAGS, 32'(1) << bp);
      rd(`NESU_OFS_OP_FLAGS, fl(4'h0), "clear");
    end
    wr(`NESU_OFS_CONTROL, 32'h0000_0700);
    ev(2);
    rd(`NESU_OFS_OP_FLAGS, fl(4'h0), "unlocked");
    wr(`NESU_OFS_CONTROL, 32'h0000_0708);
    ev(2);
    rd(`NESU_OFS_OP_FLAGS, fl(4'h8), "tight lock");
    wr(`NESU_OFS_CONTROL, 32'h0000_0700);
    @(negedge clk_in);
    check("locks", 32'({tight, lock}), 32'h0000_0002);
    wr(`NESU_OFS_OP_FLAGS, 32'h0001_0000);
    @(posedge clk_in);
    start <= 2'b11;
    @(posedge clk_in);
    start <= 2'b00;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (rdy !== 2'b11 && n < 50);
    if (n == 50) begin
      errors++;
      stop_test();
    end
    rd(`NESU_OFS_OP_FLAGS, fl(4'h1), "ready edge");
    @(posedge clk_in);
    clr <= 1'b1;
    @(posedge clk_in);
    {clr, vld, data} <= {2'b01, 16'h8010};
    @(posedge clk_in);
    spr <= 1'b1;
    @(posedge clk_in);
    {vld, spr} <= 2'b00;
    rd(`NESU_OFS_CALC_MAIN0, 32'h1000_4001, "code low");
    rd(`NESU_OFS_CALC_MAIN1, 32'h8000_7001, "code high");
    rd(`NESU_OFS_CALC_SPARE, 32'h80e1_1081, "code spare");
    clr <= 1'b1;
    @(posedge clk_in);
    clr <= 1'b0;
    // computed codes zero; stored codes set before each strobe
    for (int i = 0; i < 4; i++) begin
      stored <= '{high_lane: 24'h00_0000, low_lane: st[i]};
      wr(`NESU_OFS_MAIN_HOLD3, {24'h00_0000, h3[i]});
      strobe(1'b0);
      rd(`NESU_OFS_LANE_LOW, ex[i], "main class");
    end
    wr(`NESU_OFS_SPARE_HOLD0, 32'h0000_c500);
    wr(`NESU_OFS_SPARE_HOLD1, 32'h0000_4000);
    strobe(1'b1);
    rd(`NESU_OFS_LANE_HIGH, 32'h0058_0004, "spare");
    rd(`NESU_OFS_LANE_LOW, 32'h0000_02b1, "lane split");
    repeat (3) @(posedge clk_in);
    stop_test();
  end
endmodule
bind nesu_status_unit nesu_status_unit_assertions
  nesu_status_unit_assertions_i (.*);

// ==== verilog/nesu_defs.svh ====
/*
  offsets, field positions and reset values of the status unit.
  assumes inclusion by the design, checker and bench files.
*/
`ifndef NESU_DEFS_SVH
`define NESU_DEFS_SVH

// register byte addresses
`define NESU_OFS_MAIN_HOLD3   32'h40c0_0020
`define NESU_OFS_SPARE_HOLD0  32'h40c0_0024
`define NESU_OFS_SPARE_HOLD1  32'h4000_0028
`define NESU_OFS_OP_FLAGS     32'h40c0_002c
`define NESU_OFS_LANE_LOW     32'h40c0_0030
`define NESU_OFS_LANE_HIGH    32'h40c0_0034
`define NESU_OFS_CALC_MAIN0   32'h40c0_0038
`define NESU_OFS_CALC_MAIN1   32'h40c0_003c
`define NESU_OFS_CALC_SPARE   32'h40c0_0040
`define NESU_OFS_CONTROL      32'h40c0_0060

// operation_flags bit positions
`define NESU_FLG_PROTECT      16
`define NESU_FLG_LOAD         15
`define NESU_FLG_STORE        14
`define NESU_FLG_EDGE         13

// check result field positions
`define NESU_RES_SWORD_MSB    24
`define NESU_RES_SWORD_LSB    21
`define NESU_RES_SBIT_MSB     20
`define NESU_RES_SBIT_LSB     18
`define NESU_RES_MWORD_MSB    17
`define NESU_RES_MWORD_LSB    7
`define NESU_RES_MBIT_MSB     6
`define NESU_RES_MBIT_LSB     4
`define NESU_RES_SCLS_MSB     3
`define NESU_RES_SCLS_LSB     2
`define NESU_RES_MCLS_MSB     1
`define NESU_RES_MCLS_LSB     0

// control register bit positions
`define NESU_CTL_LOCK         2
`define NESU_CTL_TIGHT        3
`define NESU_CTL_IE_LOAD      8
`define NESU_CTL_IE_STORE     9
`define NESU_CTL_IE_EDGE      10

// reset values
`define NESU_RST_HOLD         16'h0000
`define NESU_RST_RESULT       32'h0000_0000
`define NESU_RST_LOCK         1'b1
`define NESU_RST_CHIPSEL      1'b1
`define NESU_RST_READY        1'b1

`endif

// ==== verilog/nesu_lane_ecc.sv ====
/*
  per-lane ecc engine: main and spare area codes of one byte lane.
  assumes one byte per valid cycle and a clear before a page.
*/
`timescale 1ns/1ps
module nesu_lane_ecc (
  // clock and reset
  input  wire logic               clk_in,
  input  wire logic               reset_in,
  // data stream
  input  wire logic               clear_in,
  input  wire logic               valid_in,
  input  wire logic               spare_in,
  input  wire logic [7:0]         byte_in,
  // computed codes
  output nesu_pkg::nesu_code_s    code_out
);
  import nesu_pkg::*;

  logic [31:0] main_acc;
  logic [15:0] spare_acc;
  logic [10:0] main_idx;
  logic [3:0]  spare_idx;

  // code: parity, word index, bit index, column
  wire logic       par  = ^byte_in;
  wire logic [2:0] bpar = {^(byte_in & 8'hf0), ^(byte_in & 8'hcc),
                           ^(byte_in & 8'haa)};
  wire logic [31:0] next_main  = main_acc ^ {byte_in, 9'h000, bpar,
                                 {11{par}} & main_idx, par};
  wire logic [15:0] next_spare = spare_acc ^ {byte_in, bpar,
                                 {4{par}} & spare_idx, par};

  always_ff @(posedge clk_in) begin
    if (reset_in || clear_in) begin
      main_acc  <= 32'h0000_0000;
      spare_acc <= 16'h0000;
      main_idx  <= 11'h000;
      spare_idx <= 4'h0;
    end else if (valid_in && !spare_in) begin
      main_acc <= next_main;
      main_idx <= main_idx + 11'h001;
    end else if (valid_in) begin
      spare_acc <= next_spare;
      spare_idx <= spare_idx + 4'h1;
    end
  end

  assign code_out = {main_acc, spare_acc};

endmodule

// ==== verilog/nesu_pkg.sv ====
/*
  types of the status unit and its lane ecc engine.
  assumes nothing of its surroundings.
*/
package nesu_pkg;

  typedef enum logic [1:0] {
    NESU_MODE_OFF   = 2'b00,
    NESU_MODE_LOAD  = 2'b01,
    NESU_MODE_STORE = 2'b10,
    NESU_MODE_SOFT  = 2'b11
  } nesu_mode_e;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } nesu_bus_req_s;

  typedef struct packed {
    logic [31:0] main_code;
    logic [15:0] spare_code;
  } nesu_code_s;

  // stored main code bytes 0..2 of both lanes, held outside this unit
  typedef struct packed {
    logic [23:0] high_lane;
    logic [23:0] low_lane;
  } nesu_stored_s;

endpackage

// ==== verilog/nesu_status_unit.sv ====
/*
  status unit: code holding registers, flags, lane check results
  and control bits behind a plain register port.
  assumes inputs synchronous to clk_in and a sequencer that reports
  completions, protected attempts and pin levels.
*/
// The address-and-strobe port was decided locally.
// Function
// RQ1: fourth main code register, one byte per lane
// RQ2: two spare code registers, one byte per lane
// RQ3: flag protected program or erase while locked
// RQ4: flag load completion, interrupt when enabled
// RQ5: flag store completion, interrupt when enabled
// RQ6: flag ready line transition, interrupt when enabled
// RQ7: mirror chip select level, reset to one
// RQ8: show both ready lines, one means ready
// RQ9: show boot buffer pointer in status
// RQ10: encode main and spare error class
// RQ11: report main failing word and bit
// RQ12: report spare failing word and bit
// RQ13: software trusts results only with valid codes
// RQ14: separate result registers per lane, reset zero
// RQ15: mode field selects off, load, store, software
// RQ16: lock tight sticks until reset
// RQ17: compute four main code bytes per lane
// RQ18: classify by comparing stored and computed codes
// RQ19: writing zero leaves flags unchanged
`timescale 1ns/1ps
`include "nesu_defs.svh"
module nesu_status_unit (
  // clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  reset_in,
  // register port
  input  nesu_pkg::nesu_bus_req_s    bus_in,
  output logic [31:0]                rd_data_out,
  // flash pins as seen by the controller
  input  wire logic                  ready_line_0_in,
  input  wire logic                  ready_line_1_in,
  input  wire logic                  chip_select_level_in,
  input  wire logic [9:0]            boot_buffer_pointer_in,
  // sequencer events
  input  wire logic                  load_done_in,
  input  wire logic                  store_done_in,
  input  wire logic                  protected_attempt_in,
  // ecc data stream
  input  wire logic                  ecc_clear_in,
  input  wire logic                  ecc_valid_in,
  input  wire logic                  ecc_spare_in,
  input  wire logic [15:0]           ecc_data_in,
  // stored codes and checks
  input  nesu_pkg::nesu_stored_s     stored_main_in,
  input  wire logic                  cap_valid_in,
  input  wire logic [1:0]            cap_sel_in,
  input  wire logic [15:0]           cap_data_in,
  input  wire logic                  main_check_in,
  input  wire logic                  spare_check_in,
  // control outputs
  output nesu_pkg::nesu_mode_e       mode_out,
  output logic                       lock_out,
  output logic                       lock_tight_out,
  output logic                       irq_out
);
  import nesu_pkg::*;

  function automatic logic [5:0] ones32(input logic [31:0] v);
    logic [5:0] n;
    n = 6'h00;
    for (int i = 0; i < 32; i++) begin
      n = n + {5'h00, v[i]};
    end
    return n;
  endfunction

  // a lone syndrome bit can only come from the stored code itself
  function automatic logic [1:0] classify(input logic [31:0] syn,
                                          input logic        p,
                                          input logic [2:0]  b,
                                          input logic [7:0]  col);
    logic [7:0] hit;
    hit = 8'h01 << b;
    if (syn == 32'h0000_0000) begin
      return 2'b00;                                    // RQ10
    end else if (ones32(syn) == 6'h01) begin
      return 2'b11;                                    // RQ10
    end else if (p && (col == hit)) begin
      return 2'b01;                                    // RQ10
    end else begin
      return 2'b10;                                    // RQ10
    end
  endfunction

  function automatic logic [31:0] update_result(
      input logic [31:0] old,
      input logic [31:0] msyn,
      input logic [15:0] ssyn,
      input logic        do_main,
      input logic        do_spare);
    logic [31:0] r;
    logic [1:0]  mc;
    logic [1:0]  sc;
    r  = old;
    mc = classify(msyn, msyn[0], msyn[14:12], msyn[31:24]);
    sc = classify({16'h0000, ssyn}, ssyn[0], ssyn[7:5], ssyn[15:8]);
    if (do_main) begin
      r[`NESU_RES_MCLS_MSB:`NESU_RES_MCLS_LSB] = mc;    // RQ18
      r[`NESU_RES_MWORD_MSB:`NESU_RES_MWORD_LSB] =
        (mc == 2'b01) ? msyn[11:1] : 11'h000;          // RQ11
      r[`NESU_RES_MBIT_MSB:`NESU_RES_MBIT_LSB] =
        (mc == 2'b01) ? msyn[14:12] : 3'h0;            // RQ11
    end
    if (do_spare) begin
      r[`NESU_RES_SCLS_MSB:`NESU_RES_SCLS_LSB] = sc;    // RQ18
      r[`NESU_RES_SWORD_MSB:`NESU_RES_SWORD_LSB] =
        (sc == 2'b01) ? ssyn[4:1] : 4'h0;              // RQ12
      r[`NESU_RES_SBIT_MSB:`NESU_RES_SBIT_LSB] =
        (sc == 2'b01) ? ssyn[7:5] : 3'h0;              // RQ12
    end
    return r;
  endfunction

  // holding and result registers
  logic [15:0] main_code_hold_3;
  logic [15:0] spare_code_hold_0;
  logic [15:0] spare_code_hold_1;
  logic [31:0] lane_low_check_result;
  logic [31:0] lane_high_check_result;

  // flags and mirrors
  logic        protect_violation_flag;
  logic        boot_fetch_complete;
  logic        buffer_writeback_complete;
  logic        ready_line_edge_flag;
  logic        chip_select_level;
  logic        ready_line_0;
  logic        ready_line_1;
  logic [9:0]  boot_buffer_pointer;

  // control and computed lane codes
  logic [2:0]  irq_enable;
  nesu_code_s  code_low;
  nesu_code_s  code_high;

  // address decode
  wire logic hit_main3  = bus_in.addr == `NESU_OFS_MAIN_HOLD3;
  wire logic hit_spare0 = bus_in.addr == `NESU_OFS_SPARE_HOLD0;
  wire logic hit_spare1 = bus_in.addr == `NESU_OFS_SPARE_HOLD1;
  wire logic hit_flags  = bus_in.addr == `NESU_OFS_OP_FLAGS;
  wire logic hit_low    = bus_in.addr == `NESU_OFS_LANE_LOW;
  wire logic hit_high   = bus_in.addr == `NESU_OFS_LANE_HIGH;
  wire logic hit_calc0  = bus_in.addr == `NESU_OFS_CALC_MAIN0;
  wire logic hit_calc1  = bus_in.addr == `NESU_OFS_CALC_MAIN1;
  wire logic hit_calcs  = bus_in.addr == `NESU_OFS_CALC_SPARE;
  wire logic hit_ctl    = bus_in.addr == `NESU_OFS_CONTROL;

  wire logic wr_main3  = bus_in.wr && hit_main3;
  wire logic wr_spare0 = bus_in.wr && hit_spare0;
  wire logic wr_spare1 = bus_in.wr && hit_spare1;
  wire logic wr_flags  = bus_in.wr && hit_flags;
  wire logic wr_low    = bus_in.wr && hit_low;
  wire logic wr_high   = bus_in.wr && hit_high;
  wire logic wr_ctl    = bus_in.wr && hit_ctl;

  // capture of code bytes read back from flash
  wire logic cap_main3  = cap_valid_in && (cap_sel_in == 2'd0);
  wire logic cap_spare0 = cap_valid_in && (cap_sel_in == 2'd1);
  wire logic cap_spare1 = cap_valid_in && (cap_sel_in == 2'd2);

  wire logic [15:0] next_main_code_hold_3 =
    cap_main3 ? cap_data_in :
    wr_main3  ? bus_in.wdata[15:0] : main_code_hold_3;     // RQ1
  wire logic [15:0] next_spare_code_hold_0 =
    cap_spare0 ? cap_data_in :
    wr_spare0  ? bus_in.wdata[15:0] : spare_code_hold_0;   // RQ2
  wire logic [15:0] next_spare_code_hold_1 =
    cap_spare1 ? cap_data_in :
    wr_spare1  ? bus_in.wdata[15:0] : spare_code_hold_1;   // RQ2

  // one ecc engine per byte lane
  nesu_lane_ecc u_lane_low (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .clear_in (ecc_clear_in),
    .valid_in (ecc_valid_in),
    .spare_in (ecc_spare_in),
    .byte_in  (ecc_data_in[7:0]),
    .code_out (code_low)
  );                                                       // RQ17

  nesu_lane_ecc u_lane_high (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .clear_in (ecc_clear_in),
    .valid_in (ecc_valid_in),
    .spare_in (ecc_spare_in),
    .byte_in  (ecc_data_in[15:8]),
    .code_out (code_high)
  );                                                       // RQ17

  // stored codes of each lane
  wire logic [31:0] stored_main_low =
    {main_code_hold_3[7:0], stored_main_in.low_lane};      // RQ1
  wire logic [31:0] stored_main_high =
    {main_code_hold_3[15:8], stored_main_in.high_lane};    // RQ1
  wire logic [15:0] stored_spare_low =
    {spare_code_hold_1[7:0], spare_code_hold_0[7:0]};      // RQ2
  wire logic [15:0] stored_spare_high =
    {spare_code_hold_1[15:8], spare_code_hold_0[15:8]};    // RQ2

  wire logic [31:0] syn_main_low  = stored_main_low ^ code_low.main_code;
  wire logic [31:0] syn_main_high = stored_main_high ^ code_high.main_code;
  wire logic [15:0] syn_spare_low = stored_spare_low ^ code_low.spare_code;
  wire logic [15:0] syn_spare_high =
    stored_spare_high ^ code_high.spare_code;

  // a check strobe wins over a software write in the same cycle
  wire logic any_check = main_check_in || spare_check_in;
  wire logic [31:0] next_lane_low_check_result =
    any_check ? update_result(lane_low_check_result, syn_main_low,
                              syn_spare_low, main_check_in,
                              spare_check_in) :
    wr_low    ? bus_in.wdata : lane_low_check_result;     // RQ14
  wire logic [31:0] next_lane_high_check_result =
    any_check ? update_result(lane_high_check_result, syn_main_high,
                              syn_spare_high, main_check_in,
                              spare_check_in) :
    wr_high   ? bus_in.wdata : lane_high_check_result;    // RQ14

  // sticky flags: a new event beats a write-one clear
  wire logic locked = lock_out || lock_tight_out;
  wire logic ready_edge = (ready_line_0_in != ready_line_0) ||
                          (ready_line_1_in != ready_line_1);
  wire logic next_protect_violation_flag =
    (protected_attempt_in && locked) ||                    // RQ3
    (protect_violation_flag &&
     !(wr_flags && bus_in.wdata[`NESU_FLG_PROTECT]));      // RQ19
  wire logic next_boot_fetch_complete = load_done_in ||    // RQ4
    (boot_fetch_complete &&
     !(wr_flags && bus_in.wdata[`NESU_FLG_LOAD]));         // RQ19
  wire logic next_buffer_writeback_complete = store_done_in ||  // RQ5
    (buffer_writeback_complete &&
     !(wr_flags && bus_in.wdata[`NESU_FLG_STORE]));        // RQ19
  wire logic next_ready_line_edge_flag = ready_edge ||     // RQ6
    (ready_line_edge_flag &&
     !(wr_flags && bus_in.wdata[`NESU_FLG_EDGE]));         // RQ19

  wire logic next_irq =
    (next_boot_fetch_complete && irq_enable[0]) ||         // RQ4
    (next_buffer_writeback_complete && irq_enable[1]) ||   // RQ5
    (next_ready_line_edge_flag && irq_enable[2]);          // RQ6

  // control register
  wire logic next_lock_tight = lock_tight_out ||
    (wr_ctl && bus_in.wdata[`NESU_CTL_TIGHT]);             // RQ16
  wire logic [31:0] control_view = {21'h00_0000, irq_enable, 4'h0,
                                    lock_tight_out, lock_out, mode_out};
  wire logic [31:0] flags_view = {15'h0000,
    protect_violation_flag, boot_fetch_complete,
    buffer_writeback_complete, ready_line_edge_flag,
    chip_select_level,                                     // RQ7
    ready_line_1, ready_line_0,                            // RQ8
    boot_buffer_pointer};                                  // RQ9

  // read selection; unmapped addresses read zero
  wire logic [31:0] read_mux =
    hit_main3  ? {16'h0000, main_code_hold_3}  :
    hit_spare0 ? {16'h0000, spare_code_hold_0} :
    hit_spare1 ? {16'h0000, spare_code_hold_1} :
    hit_flags  ? flags_view :
    hit_low    ? lane_low_check_result  :
    hit_high   ? lane_high_check_result :
    hit_calc0  ? code_low.main_code  :
    hit_calc1  ? code_high.main_code :
    hit_calcs  ? {code_high.spare_code, code_low.spare_code} :
    hit_ctl    ? control_view : 32'h0000_0000;
  wire logic [31:0] next_rd_data = bus_in.rd ? read_mux : 32'h0000_0000;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      main_code_hold_3  <= `NESU_RST_HOLD;
      spare_code_hold_0 <= `NESU_RST_HOLD;
      spare_code_hold_1 <= `NESU_RST_HOLD;
    end else begin
      main_code_hold_3  <= next_main_code_hold_3;
      spare_code_hold_0 <= next_spare_code_hold_0;
      spare_code_hold_1 <= next_spare_code_hold_1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      lane_low_check_result  <= `NESU_RST_RESULT;         // RQ14
      lane_high_check_result <= `NESU_RST_RESULT;         // RQ14
    end else begin
      lane_low_check_result  <= next_lane_low_check_result;
      lane_high_check_result <= next_lane_high_check_result;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      protect_violation_flag    <= 1'b0;
      boot_fetch_complete       <= 1'b0;
      buffer_writeback_complete <= 1'b0;
      ready_line_edge_flag      <= 1'b0;
      irq_out                   <= 1'b0;
    end else begin
      protect_violation_flag    <= next_protect_violation_flag;
      boot_fetch_complete       <= next_boot_fetch_complete;
      buffer_writeback_complete <= next_buffer_writeback_complete;
      ready_line_edge_flag      <= next_ready_line_edge_flag;
      irq_out                   <= next_irq;
    end
  end

  // pin mirrors; the ready history also feeds the edge detector
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      chip_select_level   <= `NESU_RST_CHIPSEL;            // RQ7
      ready_line_0        <= `NESU_RST_READY;
      ready_line_1        <= `NESU_RST_READY;
      boot_buffer_pointer <= 10'h000;
    end else begin
      chip_select_level   <= chip_select_level_in;         // RQ7
      ready_line_0        <= ready_line_0_in;              // RQ8
      ready_line_1        <= ready_line_1_in;              // RQ8
      boot_buffer_pointer <= boot_buffer_pointer_in;       // RQ9
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      mode_out       <= NESU_MODE_OFF;
      lock_out       <= `NESU_RST_LOCK;
      lock_tight_out <= 1'b0;
      irq_enable     <= 3'h0;
    end else begin
      lock_tight_out <= next_lock_tight;                   // RQ16
      if (wr_ctl) begin
        mode_out   <= nesu_mode_e'(bus_in.wdata[1:0]);     // RQ15
        lock_out   <= bus_in.wdata[`NESU_CTL_LOCK];
        irq_enable <= {bus_in.wdata[`NESU_CTL_IE_EDGE],
                       bus_in.wdata[`NESU_CTL_IE_STORE],
                       bus_in.wdata[`NESU_CTL_IE_LOAD]};
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rd_data_out <= 32'h0000_0000;
    end else begin
      rd_data_out <= next_rd_data;
    end
  end

endmodule
